/* core/loop_alarm_and_contact_action.sv */
// loop alarm evaluation and contact-triggered mode switching, one loop
// assumes loop core status inputs and contact output states are on clk_i;
// contact inputs are field pins and are synchronised here
// Summary of operation
// - four alarm setpoints per loop, each evaluated independently
// - eleven alarm types; relay polarity follows energize or de-energize action
// - standby hides an alarm until first false; re-armed on listed changes
// - alarm modes: always, off when stopped, off when manual or stopped
// - arising condition starts on-delay; alarm asserts when it expires
// - clearing condition starts off-delay; alarm drops when it expires
// - leaving alarm region during on-delay resets timer, no alarm
// - each comparison uses its own hysteresis band
// - acknowledge releases all latched indications and relays whose alarm is no longer active
// - sources: eight contact inputs, eight contact outputs, four levels, four states
// - level ignores relay action; state includes it
// - actions only drive this module's own functions
// - mode toggles, tuning and input switch act on edges, opposite states
// - mode switches, acknowledge, setpoint and PID number bits are triggers
// - energize rising-edge action fires on inactive to active
// - energize falling-edge action fires on active to inactive
// - trigger needs source held beyond one control period
// - in program operation alarms may watch value, setpoint, output, events
`include "loop_alarm_map.svh"
`timescale 1ns/1ps
module loop_alarm_and_contact_action
#(
  parameter int CTRL_PERIOD_CYCLES = `CTRL_PERIOD_CYC // control period in clocks
)
(
  input wire logic clk_i, // 50 MHz clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic signed [15:0] process_value_i, // measured value
  input wire logic signed [15:0] setpoint_i, // working setpoint
  input wire logic signed [15:0] control_output_i, // control output
  input wire logic program_mode_i, // program operation running
  input wire logic [3:0] program_event_i, // program events per alarm
  input wire logic run_i, // loop running, low when stopped
  input wire logic manual_mode_i, // loop in manual
  input wire logic local_mode_i, // loop in local
  input wire logic ack_i, // operator acknowledge pulse
  input wire logic [3:0][3:0] alarm_type_i, // type per alarm
  input wire logic [3:0][15:0] alarm_limit_i, // threshold per alarm
  input wire logic [3:0][15:0] alarm_hyst_i, // hysteresis per alarm
  input wire logic [3:0][7:0] on_delay_i, // on-delay in ticks
  input wire logic [3:0][7:0] off_delay_i, // off-delay in ticks
  input wire logic [3:0] standby_en_i, // standby per alarm
  input wire logic [3:0] latch_en_i, // latching relay action
  input wire logic [3:0] energize_i, // 1 energize, 0 de-energize
  input wire loop_alarm_pkg::alarm_mode_t [3:0] alarm_mode_i, // enable mode
  input wire logic [7:0] contact_input_i, // field contact pins
  input wire logic [7:0] contact_out_state_i, // contact output states
  input wire loop_alarm_pkg::src_sel_t [18:0] action_src_i, // source per action
  input wire logic [18:0] action_deenergize_i, // invert source sense
  output logic [3:0] alarm_level_o, // alarm status, no latch
  output logic [3:0] alarm_state_o, // status with relay action
  output logic [3:0] alarm_relay_o, // relay drive
  output logic auto_req_o, // switch to auto pulse
  output logic manual_req_o, // switch to manual pulse
  output logic remote_req_o, // switch to remote pulse
  output logic local_req_o, // switch to local pulse
  output logic cascade_req_o, // switch to cascade pulse
  output logic stop_req_o, // stop pulse
  output logic run_req_o, // run pulse
  output logic tune_start_o, // auto-tuning start pulse
  output logic tune_stop_o, // auto-tuning stop pulse
  output logic pv_alt_sel_o, // second input selected
  output logic [3:0] setpoint_num_o, // setpoint number bits
  output logic [3:0] pid_num_o // PID number bits
);
  import loop_alarm_pkg::*;

  // alarm test with hysteresis; active alarms need to back off by the band
  function automatic logic alarm_test(input logic [3:0] typ, input wide_t pv,
    input wide_t sp, input wide_t out, input wide_t lim, input wide_t hys,
    input logic prev, input logic prog, input logic evt);
    wide_t dev;
    wide_t th;
    logic r;
    dev = pv - sp;
    th = prev ? lim - hys : lim;
    r = 1'b0;
    case (typ)
      `ATYPE_PV_HI: r = pv >= th;
      `ATYPE_PV_LO: r = pv <= (prev ? lim + hys : lim);
      `ATYPE_DEV_HI: r = dev >= th;
      `ATYPE_DEV_LO: r = dev <= -th;
      `ATYPE_DEV_HILO: r = (dev >= th) || (dev <= -th);
      `ATYPE_DEV_BAND: r = (dev <= (prev ? lim + hys : lim)) && (dev >= -(prev ? lim + hys : lim));
      `ATYPE_SP_HI: r = sp >= th;
      `ATYPE_SP_LO: r = sp <= (prev ? lim + hys : lim);
      `ATYPE_OUT_HI: r = out >= th;
      `ATYPE_OUT_LO: r = out <= (prev ? lim + hys : lim);
      `ATYPE_PROG_EVT: r = prog & evt;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic [$clog2(`CTRL_PERIOD_CYC + 1)-1:0] div_reg;
  logic tick_reg;
  logic [7:0] ci_meta_reg;
  logic [7:0] ci_sync_reg;
  logic [3:0] cond_reg;
  logic [3:0][3:0] type_prev_reg;
  logic signed [15:0] sp_prev_reg;
  logic ack_pulse_reg;
  logic [31:0] src_vec;
  logic [18:0] ev;
  logic [18:0] ev_prev_reg;
  logic [14:0][1:0] held_reg;
  logic [14:0] fire;
  logic [3:0] level_w;
  logic [3:0] state_w;
  logic [3:0] relay_w;

  alarm_if ai[4] ();

  // control period divider; the period is long so it is a parameter
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (div_reg >= ($bits(div_reg))'(CTRL_PERIOD_CYCLES - 1))
    begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      div_reg <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // field contacts cross in through two flops
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ci_meta_reg <= 8'h00;
      ci_sync_reg <= 8'h00;
    end
    else
    begin
      ci_meta_reg <= contact_input_i;
      ci_sync_reg <= ci_meta_reg;
    end
  end

  // hysteresis-filtered conditions, evaluated once per control period
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cond_reg <= 4'h0;
    else if (tick_reg)
      for (int i = 0; i < `ALARM_CNT; i++)
        cond_reg[i] <= alarm_test(alarm_type_i[i], wide_t'(process_value_i),
          wide_t'(setpoint_i), wide_t'(control_output_i), wide_t'($signed(alarm_limit_i[i])),
          wide_t'({1'b0, alarm_hyst_i[i]}), cond_reg[i], program_mode_i,
          program_event_i[i]);
  end

  // sampled once a period, so arm also spans the first tick after reset
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      type_prev_reg <= '0;
      sp_prev_reg <= 16'h0000;
    end
    else if (tick_reg)
    begin
      type_prev_reg <= alarm_type_i;
      sp_prev_reg <= setpoint_i;
    end
  end

  // acknowledge from the operator or from a qualified trigger
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ack_pulse_reg <= 1'b0;
    else
      ack_pulse_reg <= ack_i | fire[`ACT_ACK - `ACT_CASCADE];
  end

  // hook up the four channels; a number change only counts if the setpoint moves
  for (genvar g = 0; g < `ALARM_CNT; g++)
  begin : g_alarm
    assign ai[g].tick = tick_reg;
    assign ai[g].cond = cond_reg[g];
    assign ai[g].enable = (alarm_mode_i[g] == MODE_ALWAYS)
      || ((alarm_mode_i[g] == MODE_NOT_STOP) && run_i)
      || ((alarm_mode_i[g] == MODE_NOT_MAN_STOP) && run_i && !manual_mode_i);
    assign ai[g].arm = (local_mode_i && (setpoint_i != sp_prev_reg))
      || (alarm_type_i[g] != type_prev_reg[g]);
    assign ai[g].ack = ack_pulse_reg;
    assign ai[g].standby_en = standby_en_i[g];
    assign ai[g].latch_en = latch_en_i[g];
    assign ai[g].energize = energize_i[g];
    assign ai[g].on_delay = on_delay_i[g];
    assign ai[g].off_delay = off_delay_i[g];
    assign level_w[g] = ai[g].level;
    assign state_w[g] = ai[g].state;
    assign relay_w[g] = ai[g].relay;
    alarm_channel u_chan
    (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .a(ai[g])
    );
  end

  // alarm outputs: channel flops passed straight through
  assign alarm_level_o = level_w;
  assign alarm_state_o = state_w;
  assign alarm_relay_o = relay_w;

  // event source table, unused codes read inactive
  assign src_vec = {8'h00, state_w, level_w, contact_out_state_i,
    ci_sync_reg};

  // per-action source pick; de-energize inverts the sense
  always_comb
  begin
    for (int k = 0; k < `ACT_CNT; k++)
      ev[k] = (action_src_i[k] == `SRC_NONE) ? 1'b0
        : src_vec[action_src_i[k]] ^ action_deenergize_i[k];
  end

  // previous event levels for edge detection
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ev_prev_reg <= '0;
    else
      ev_prev_reg <= ev;
  end

  // trigger qualification: count ticks while the source stays on
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      held_reg <= '0;
    else
      for (int k = 0; k < 15; k++)
        if (!ev[k + `ACT_CASCADE])
          held_reg[k] <= 2'h0;
        else if (tick_reg && (held_reg[k] != 2'h3))
          held_reg[k] <= held_reg[k] + 2'h1;
  end

  // one fire per activation, once held past a full control period
  always_comb
  begin
    for (int k = 0; k < 15; k++)
      fire[k] = tick_reg && ev[k + `ACT_CASCADE]
        && (held_reg[k] == `TRIG_HELD - 2'h1);
  end

  // mode requests from edges and qualified triggers; rising and falling pick opposite states
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      auto_req_o <= 1'b0;
      manual_req_o <= 1'b0;
      remote_req_o <= 1'b0;
      local_req_o <= 1'b0;
      cascade_req_o <= 1'b0;
      stop_req_o <= 1'b0;
      run_req_o <= 1'b0;
      tune_start_o <= 1'b0;
      tune_stop_o <= 1'b0;
    end
    else
    begin
      auto_req_o <= (ev[`ACT_AUTO_MAN] & ~ev_prev_reg[`ACT_AUTO_MAN])
        | fire[`ACT_AUTO - `ACT_CASCADE];
      manual_req_o <= (~ev[`ACT_AUTO_MAN] & ev_prev_reg[`ACT_AUTO_MAN])
        | fire[`ACT_MAN - `ACT_CASCADE];
      remote_req_o <= (ev[`ACT_REM_LCL] & ~ev_prev_reg[`ACT_REM_LCL])
        | fire[`ACT_REMOTE - `ACT_CASCADE];
      local_req_o <= (~ev[`ACT_REM_LCL] & ev_prev_reg[`ACT_REM_LCL])
        | fire[`ACT_LOCAL - `ACT_CASCADE];
      cascade_req_o <= fire[0];
      stop_req_o <= ev[`ACT_STOP_RUN] & ~ev_prev_reg[`ACT_STOP_RUN];
      run_req_o <= ~ev[`ACT_STOP_RUN] & ev_prev_reg[`ACT_STOP_RUN];
      tune_start_o <= ev[`ACT_TUNE] & ~ev_prev_reg[`ACT_TUNE];
      tune_stop_o <= ~ev[`ACT_TUNE] & ev_prev_reg[`ACT_TUNE];
    end
  end

  // input switching held as a level, set and cleared by edges
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pv_alt_sel_o <= 1'b0;
    else if (ev[`ACT_PV_SW] & ~ev_prev_reg[`ACT_PV_SW])
      pv_alt_sel_o <= 1'b1;
    else if (~ev[`ACT_PV_SW] & ev_prev_reg[`ACT_PV_SW])
      pv_alt_sel_o <= 1'b0;
  end

  // number bits: set by a qualified trigger, dropped when the source goes off;
  // only this loop's selectors are driven
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      setpoint_num_o <= 4'h0;
      pid_num_o <= 4'h0;
    end
    else
      for (int b = 0; b < 4; b++)
      begin
        if (fire[`ACT_SPNUM0 - `ACT_CASCADE + b])
          setpoint_num_o[b] <= 1'b1;
        else if (!ev[`ACT_SPNUM0 + b])
          setpoint_num_o[b] <= 1'b0;
        if (fire[`ACT_PIDNUM0 - `ACT_CASCADE + b])
          pid_num_o[b] <= 1'b1;
        else if (!ev[`ACT_PIDNUM0 + b])
          pid_num_o[b] <= 1'b0;
      end
  end
endmodule

/* core/loop_alarm_map.svh */
// constants for the loop alarm and contact action block
// assumes a 50 MHz clock; included by its bare name
`ifndef LOOP_ALARM_MAP_SVH
`define LOOP_ALARM_MAP_SVH
`define CLK_PERIOD_NS 20
`define CTRL_PERIOD_MS 100
`define CTRL_PERIOD_CYC ((`CTRL_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define ALARM_CNT 4
`define VALUE_W 16
`define DELAY_W 8
// alarm type codes, 0 disables the setpoint
`define ATYPE_OFF 4'h0
`define ATYPE_PV_HI 4'h1
`define ATYPE_PV_LO 4'h2
`define ATYPE_DEV_HI 4'h3
`define ATYPE_DEV_LO 4'h4
`define ATYPE_DEV_HILO 4'h5
`define ATYPE_DEV_BAND 4'h6
`define ATYPE_SP_HI 4'h7
`define ATYPE_SP_LO 4'h8
`define ATYPE_OUT_HI 4'h9
`define ATYPE_OUT_LO 4'ha
`define ATYPE_PROG_EVT 4'hb
// event source select ranges
`define SRC_CI_BASE 5'h00
`define SRC_CO_BASE 5'h08
`define SRC_LVL_BASE 5'h10
`define SRC_STATE_BASE 5'h14
`define SRC_NONE 5'h1f
// action slots: edge actions first, then triggers
`define ACT_CNT 19
`define ACT_AUTO_MAN 0
`define ACT_REM_LCL 1
`define ACT_STOP_RUN 2
`define ACT_TUNE 3
`define ACT_PV_SW 4
`define ACT_CASCADE 5
`define ACT_AUTO 6
`define ACT_MAN 7
`define ACT_REMOTE 8
`define ACT_LOCAL 9
`define ACT_ACK 10
`define ACT_SPNUM0 11
`define ACT_PIDNUM0 15
`define TRIG_HELD 2'h2
`endif

/* core/loop_alarm_pkg.sv */
// shared types for the loop alarm and contact action block
// constants live in loop_alarm_map.svh
package loop_alarm_pkg;
  typedef enum logic [1:0] {MODE_ALWAYS, MODE_NOT_STOP, MODE_NOT_MAN_STOP} alarm_mode_t;
  typedef logic signed [16:0] wide_t;
  typedef logic [4:0] src_sel_t;
  typedef logic [7:0] delay_t;
endpackage

/* core/alarm_if.sv */
// carrier between the alarm evaluator and one alarm channel
// all signals on the single system clock
`timescale 1ns/1ps
interface alarm_if;
  logic tick;
  logic enable;
  logic cond;
  logic arm;
  logic ack;
  logic standby_en;
  logic latch_en;
  logic energize;
  logic [7:0] on_delay;
  logic [7:0] off_delay;
  logic level;
  logic state;
  logic relay;
  modport main (output tick, enable, cond, arm, ack, standby_en, latch_en, energize,
    on_delay, off_delay, input level, state, relay);
  modport chan (input tick, enable, cond, arm, ack, standby_en, latch_en, energize,
    on_delay, off_delay, output level, state, relay);
endinterface

/* core/alarm_channel.sv */
// one alarm setpoint: standby, on/off delay, latch and relay drive
// assumes cond is already hysteresis-filtered and tick is a one-cycle enable
`timescale 1ns/1ps
module alarm_channel
(
  input wire logic clk_i, // system clock
  input wire logic reset_i, // synchronous, active high
  alarm_if.chan a // alarm control and status
);
  import loop_alarm_pkg::*;
  typedef enum {ST_IDLE, ST_ON_WAIT, ST_ACTIVE, ST_OFF_WAIT} chan_state_t;
  chan_state_t st_reg;
  logic [7:0] cnt_reg;
  logic standby_reg;
  logic hold_reg;
  logic qual;

  // standby masks the condition until it has once been false
  assign qual = a.cond & a.enable & ~(a.standby_en & standby_reg);

  // re-arm wins over the release in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      standby_reg <= 1'b1;
    else if (a.arm)
      standby_reg <= 1'b1;
    else if (a.tick && !a.cond)
      standby_reg <= 1'b0;
  end

  // delay sequencing, counted in control periods
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
    end
    else if (!a.enable)
    begin
      st_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
    end
    else if (a.tick)
    begin
      unique case (st_reg)
        ST_IDLE:
          if (qual)
          begin
            st_reg <= (a.on_delay == 8'h00) ? ST_ACTIVE : ST_ON_WAIT;
            cnt_reg <= 8'h01;
          end
        ST_ON_WAIT:
          if (!qual)
          begin
            st_reg <= ST_IDLE;
            cnt_reg <= 8'h00;
          end
          else if (cnt_reg >= a.on_delay)
            st_reg <= ST_ACTIVE;
          else
            cnt_reg <= cnt_reg + 8'h01;
        ST_ACTIVE:
          if (!qual)
          begin
            st_reg <= (a.off_delay == 8'h00) ? ST_IDLE : ST_OFF_WAIT;
            cnt_reg <= 8'h01;
          end
        ST_OFF_WAIT:
          if (qual)
          begin
            st_reg <= ST_ACTIVE; // condition back, off timer dropped
            cnt_reg <= 8'h00;
          end
          else if (cnt_reg >= a.off_delay)
            st_reg <= ST_IDLE;
          else
            cnt_reg <= cnt_reg + 8'h01;
      endcase
    end
  end

  // unlatched status, shown as the alarm level
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      a.level <= 1'b0;
    else
      a.level <= (st_reg == ST_ACTIVE) || (st_reg == ST_OFF_WAIT);
  end

  // latch: a live alarm keeps it set even against an acknowledge
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      hold_reg <= 1'b0;
    else if (a.level)
      hold_reg <= 1'b1;
    else if (a.ack)
      hold_reg <= 1'b0;
  end

  // status with relay action and its relay polarity
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      a.state <= 1'b0;
      a.relay <= 1'b0;
    end
    else
    begin
      a.state <= a.latch_en ? (hold_reg | a.level) : a.level;
      a.relay <= a.energize ? (a.latch_en ? (hold_reg | a.level) : a.level)
        : ~(a.latch_en ? (hold_reg | a.level) : a.level);
    end
  end
endmodule

/* sim/loop_alarm_asserts.sv */
// port-level checker for the loop alarm and contact action block
// sees only top-level ports; bound to the top module below
`timescale 1ns/1ps
`include "loop_alarm_map.svh"
module loop_alarm_asserts
  import loop_alarm_pkg::*;
#(
  parameter int CTRL_PERIOD_CYCLES = 8 // control period in clocks
)
(
  input wire logic clk_i, // clock
  input wire logic reset_i, // sync reset
  input wire logic run_i, // loop running
  input wire loop_alarm_pkg::alarm_mode_t [3:0] alarm_mode_i, // alarm modes
  input wire logic [3:0] energize_i, // relay sense
  input wire loop_alarm_pkg::src_sel_t [18:0] action_src_i, // action sources
  input wire logic [18:0] action_deenergize_i, // inverted sense
  input wire logic [7:0] contact_out_state_i, // contact outputs
  input wire logic [3:0] alarm_level_o, // unlatched level
  input wire logic [3:0] alarm_state_o, // latched state
  input wire logic [3:0] alarm_relay_o, // relay drive
  input wire logic auto_req_o, // auto pulse
  input wire logic manual_req_o, // manual pulse
  input wire logic stop_req_o, // stop pulse
  input wire logic run_req_o, // run pulse
  input wire logic [3:0] setpoint_num_o // setpoint bits
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  logic [7:0] held_reg;
  // cycles contact output 2 has stayed on; saturates so long holds never wrap
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !contact_out_state_i[2])
      held_reg <= 8'h00;
    else if (held_reg != 8'hff)
      held_reg <= held_reg + 8'h01;
  end
  chk_reset_quiet: assert property ($fell(reset_i) |->
    (alarm_level_o | alarm_state_o | setpoint_num_o) == 4'h0 && !auto_req_o && !stop_req_o)
    else $error("outputs not clear after reset");
  chk_relay_sense: assert property (!$past(reset_i) && !$past(reset_i, 2) &&
    $stable(energize_i) && $stable(alarm_state_o) |->
    alarm_relay_o == (alarm_state_o ~^ energize_i))
    else $error("relay sense does not match state");
  chk_level_state: assert property (
    !(|(alarm_level_o & ~alarm_state_o & $past(alarm_level_o & ~alarm_state_o))))
    else $error("level active without state");
  chk_auto_pulse: assert property (auto_req_o |=> !auto_req_o)
    else $error("auto request longer than one cycle");
  chk_mode_excl: assert property (!(auto_req_o && manual_req_o) &&
    !(stop_req_o && run_req_o))
    else $error("opposite requests together");
  chk_edge_rise: assert property (action_src_i[0] == `SRC_CO_BASE &&
    !action_deenergize_i[0] &&
    $rose(contact_out_state_i[0]) && !$past(reset_i) |-> ##[1:2] auto_req_o)
    else $error("rising edge gave no auto request");
  chk_edge_fall: assert property (action_src_i[0] == `SRC_CO_BASE &&
    !action_deenergize_i[0] &&
    $fell(contact_out_state_i[0]) && !$past(reset_i) |-> ##[1:2] manual_req_o)
    else $error("falling edge gave no manual request");
  chk_trig_hold: assert property ($rose(setpoint_num_o[0]) &&
    action_src_i[11] == `SRC_CO_BASE + 5'h02 |-> held_reg >= CTRL_PERIOD_CYCLES)
    else $error("trigger fired before a full period");
  chk_mode_stop: assert property (!($rose(alarm_level_o[0]) &&
    alarm_mode_i[0] != MODE_ALWAYS && !run_i && !$past(run_i, 4)))
    else $error("alarm raised while stopped");
endmodule
bind loop_alarm_and_contact_action loop_alarm_asserts #(.CTRL_PERIOD_CYCLES(CTRL_PERIOD_CYCLES))
  u_chk (.clk_i, .reset_i, .run_i, .alarm_mode_i, .energize_i, .action_src_i,
  .action_deenergize_i, .contact_out_state_i, .alarm_level_o, .alarm_state_o, .alarm_relay_o,
  .auto_req_o, .manual_req_o, .stop_req_o, .run_req_o, .setpoint_num_o);

/* sim/loop_core_model.sv */
// loop core stand-in: keeps run, manual and local levels from request pulses
// requests are one-cycle pulses on the block's own clock
`timescale 1ns/1ps
module loop_core_model
(
  input wire logic clk_i, // clock
  input wire logic reset_i, // sync reset
  input wire logic auto_req_i, // go auto
  input wire logic manual_req_i, // go manual
  input wire logic remote_req_i, // go remote
  input wire logic local_req_i, // go local
  input wire logic stop_req_i, // stop
  input wire logic run_req_i, // run
  output logic run_o, // running
  output logic manual_mode_o, // in manual
  output logic local_o // in local
);
  // starts running in auto and local; a request only moves its own loop
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      run_o <= 1'b1;
      manual_mode_o <= 1'b0;
      local_o <= 1'b1;
    end
    else
    begin
      if (stop_req_i || run_req_i)
        run_o <= run_req_i;
      if (auto_req_i || manual_req_i)
        manual_mode_o <= manual_req_i;
      if (remote_req_i || local_req_i)
        local_o <= local_req_i;
    end
  end
endmodule

/* sim/testbench.sv */
// self-checking bench for the loop alarm and contact action block
// loop core stand-in closes the mode loop; control period cut to 8 clocks
`timescale 1ns/1ps
`include "loop_alarm_map.svh"
module testbench;
  import loop_alarm_pkg::*;
  localparam int P = 8;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ack = 1'b0;
  logic signed [15:0] pv = 16'sh0000;
  logic [3:0][3:0] atype;
  logic [3:0][15:0] alim, ahys;
  logic [3:0][7:0] ond, offd;
  logic [3:0] stby, latch, ener, lvl, st, rly, spn, pidn;
  alarm_mode_t [3:0] amode;
  logic [7:0] ci, co;
  src_sel_t [18:0] asrc;
  logic areq, mreq, rreq, lreq, creq, sreq, rnreq, tst, tsp, pvsel, run, manual_mode, lcl;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_auto = 0, n_man = 0, n_stop = 0, n_run = 0;

  always #10 clk_i = ~clk_i;

  loop_alarm_and_contact_action #(.CTRL_PERIOD_CYCLES(P)) DUT (.clk_i, .reset_i,
    .process_value_i(pv), .setpoint_i(16'sh0000), .control_output_i(16'sh0000),
    .program_mode_i(1'b0), .program_event_i(4'h0), .run_i(run), .manual_mode_i(manual_mode),
    .local_mode_i(lcl), .ack_i(ack), .alarm_type_i(atype), .alarm_limit_i(alim),
    .alarm_hyst_i(ahys), .on_delay_i(ond), .off_delay_i(offd), .standby_en_i(stby),
    .latch_en_i(latch), .energize_i(ener), .alarm_mode_i(amode), .contact_input_i(ci),
    .contact_out_state_i(co), .action_src_i(asrc), .action_deenergize_i(19'h00000),
    .alarm_level_o(lvl), .alarm_state_o(st), .alarm_relay_o(rly), .auto_req_o(areq),
    .manual_req_o(mreq), .remote_req_o(rreq), .local_req_o(lreq), .cascade_req_o(creq),
    .stop_req_o(sreq), .run_req_o(rnreq), .tune_start_o(tst), .tune_stop_o(tsp),
    .pv_alt_sel_o(pvsel), .setpoint_num_o(spn), .pid_num_o(pidn));

  loop_core_model partner (.clk_i, .reset_i, .auto_req_i(areq), .manual_req_i(mreq),
    .remote_req_i(rreq), .local_req_i(lreq), .stop_req_i(sreq), .run_req_i(rnreq),
    .run_o(run), .manual_mode_o(manual_mode), .local_o(lcl));

  // pulse counts let tests judge one-cycle requests without racing them
  always @(posedge clk_i)
  begin
    cyc++;
    n_auto += (areq === 1'b1);
    n_man += (mreq === 1'b1);
    n_stop += (sreq === 1'b1);
    n_run += (rnreq === 1'b1);
    if (cyc == 5000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n * P) @(posedge clk_i);
  endtask

  task automatic set_pv(input logic signed [15:0] v);
    @(posedge clk_i);
    pv <= v;
  endtask

  task automatic t_reset();
    check(lvl, 4'h0);
    check(st | spn, 4'h0);
    check(rly, 4'h2);
    $display("reset test done");
  endtask

  // two high alarms of opposite relay sense; hysteresis holds 95, drops 85
  task automatic t_alarm();
    set_pv(16'sh00c8);
    ticks(3);
    check(lvl, 4'h3);
    check(rly, 4'h1);
    set_pv(16'sh005f);
    ticks(3);
    check(lvl, 4'h3);
    set_pv(16'sh0055);
    ticks(3);
    check(lvl, 4'h0);
    check(rly, 4'h2);
    $display("alarm test done");
  endtask

  task automatic t_delay();
    set_pv(16'sh00c8);
    ond[0] <= 8'h04;
    offd[0] <= 8'h02;
    ticks(2);
    pv <= 16'sh0000;
    ticks(6);
    check(lvl & 4'h1, 4'h0);
    pv <= 16'sh00c8;
    ticks(3);
    check(lvl & 4'h1, 4'h0);
    ticks(4);
    check(lvl & 4'h1, 4'h1);
    pv <= 16'sh0000;
    ticks(2);
    check(lvl & 4'h1, 4'h1);
    ticks(3);
    check(lvl & 4'h1, 4'h0);
    ond[0] <= 8'h00;
    offd[0] <= 8'h00;
    $display("delay test done");
  endtask

  task automatic t_latch();
    set_pv(16'sh00c8);
    latch <= 4'h3;
    ticks(3);
    pv <= 16'sh0000;
    ticks(3);
    check(lvl & 4'h3, 4'h0);
    check(st & 4'h3, 4'h3);
    check(rly & 4'h3, 4'h1);
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    ticks(2);
    check(st & 4'h3, 4'h0);
    latch <= 4'h0;
    $display("latch test done");
  endtask

  // stop and manual come through edge actions on contact outputs 1 and 0
  task automatic t_mode();
    int a0, m0, s0, r0;
    a0 = n_auto;
    m0 = n_man;
    s0 = n_stop;
    r0 = n_run;
    set_pv(16'sh00c8);
    amode[0] <= MODE_NOT_STOP;
    co[0] <= 1'b1;
    ticks(3);
    co[1] <= 1'b1;
    ticks(3);
    check(lvl & 4'h1, 4'h0);
    co[1] <= 1'b0;
    ticks(3);
    check(lvl & 4'h1, 4'h1);
    amode[0] <= MODE_NOT_MAN_STOP;
    co[0] <= 1'b0;
    ticks(3);
    check(lvl & 4'h1, 4'h0);
    co[0] <= 1'b1;
    ticks(3);
    check(lvl & 4'h1, 4'h1);
    check(4'(n_stop - s0), 4'h1);
    check(4'(n_run - r0), 4'h1);
    check(4'(n_auto - a0), 4'h2);
    check(4'(n_man - m0), 4'h1);
    check(4'(pvsel), 4'h1);
    amode[0] <= MODE_ALWAYS;
    pv <= 16'sh0000;
    ticks(3);
    $display("mode test done");
  endtask

  // a hold shorter than one period must not count
  task automatic t_trigger();
    co[2] <= 1'b1;
    ci[0] <= 1'b1;
    repeat (4) @(posedge clk_i);
    co[2] <= 1'b0;
    ci[0] <= 1'b0;
    ticks(3);
    check({pidn[0], spn[0]}, 4'h0);
    co[2] <= 1'b1;
    ci[0] <= 1'b1;
    ticks(3);
    check({pidn[0], spn[0]}, 4'h3);
    co[2] <= 1'b0;
    ci[0] <= 1'b0;
    ticks(1);
    check({pidn[0], spn[0]}, 4'h0);
    $display("trigger test done");
  endtask

  task automatic t_standby();
    set_pv(16'sh00c8);
    stby <= 4'h1;
    reset_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    ticks(4);
    check(lvl & 4'h1, 4'h0);
    pv <= 16'sh0000;
    ticks(2);
    pv <= 16'sh00c8;
    ticks(3);
    check(lvl & 4'h1, 4'h1);
    $display("standby test done");
  endtask

  initial
  begin
    atype = {`ATYPE_PV_LO, `ATYPE_OFF, `ATYPE_PV_HI, `ATYPE_PV_HI};
    alim = {16'hff9c, 16'h0064, 16'h0064, 16'h0064};
    ahys = {4{16'h000a}};
    ond = {4{8'h00}};
    offd = {4{8'h00}};
    stby = 4'h0;
    latch = 4'h0;
    ener = 4'hd;
    ci = 8'h00;
    co = 8'h00;
    foreach (amode[i]) amode[i] = MODE_ALWAYS;
    foreach (asrc[i]) asrc[i] = `SRC_NONE;
    asrc[`ACT_AUTO_MAN] = `SRC_CO_BASE;
    asrc[`ACT_STOP_RUN] = `SRC_CO_BASE + 5'h01;
    asrc[`ACT_SPNUM0] = `SRC_CO_BASE + 5'h02;
    asrc[`ACT_PIDNUM0] = `SRC_CI_BASE;
    asrc[`ACT_PV_SW] = `SRC_CO_BASE;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_alarm();
    t_delay();
    t_latch();
    t_mode();
    t_trigger();
    t_standby();
    finish_test();
  end
endmodule
